// ===== src/pei_pkg.sv
// package: constants and types for the phy event interrupt status block
package pei_pkg;
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************
  // management register map
  // ***************************************************
  localparam logic [4:0] PEI_ADDR_IRQ_CTRL_STATUS = 5'h11;
  localparam logic [4:0] PEI_ADDR_AUTONEG_DIAG = 5'h12;
  localparam logic [15:0] PEI_IRQ_CTRL_STATUS_RESET = 16'h0000;
  localparam logic [15:0] PEI_AUTONEG_DIAG_RESET = 16'h0000;
  localparam logic [7:0] PEI_FLAGS_RESET = 8'h00;
  localparam logic [7:0] PEI_ENABLES_RESET = 8'h00;

  // field layout: flags in the low byte, enables in the high byte
  localparam int PEI_FLAG_LSB = 0;
  localparam int PEI_FLAG_MSB = 7;
  localparam int PEI_EN_LSB = 8;
  localparam int PEI_EN_MSB = 15;

  // ***************************************************
  // management frame format
  // ***************************************************
  localparam logic [1:0] PEI_OP_READ = 2'h2;
  localparam logic [1:0] PEI_OP_WRITE = 2'h1;
  localparam logic [5:0] PEI_PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] PEI_CNT_OP_LAST = 5'h01;
  localparam logic [4:0] PEI_CNT_ADDR_LAST = 5'h04;
  localparam logic [4:0] PEI_CNT_TA_LAST = 5'h01;
  localparam logic [4:0] PEI_CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0] PEI_CNT_ZERO = 5'h00;
  localparam logic [4:0] PEI_CNT_ONE = 5'h01;
  localparam logic [5:0] PEI_PRE_ONE = 6'h01;
  localparam logic [5:0] PEI_PRE_ZERO = 6'h00;

  // ***************************************************
  // types
  // ***************************************************
  // one bit per phy event, in register bit order
  typedef struct packed {
    logic babble;
    logic rx_fault;
    logic page_arrival;
    logic parallel_detect_fault;
    logic partner_ack;
    logic link_drop;
    logic far_end_fault;
    logic autoneg_done;
  } pei_events_t;

  // management pin drive pair, mdio already split into out/enable
  typedef struct packed {
    logic mdio_o;
    logic mdio_oe;
  } pei_mdio_drv_t;

  typedef enum logic [2:0] {
    PEI_ST_IDLE,
    PEI_ST_START,
    PEI_ST_OP,
    PEI_ST_PHYAD,
    PEI_ST_REGAD,
    PEI_ST_TA,
    PEI_ST_DATA
  } pei_state_t;

endpackage

// ===== src/pei_phy_event_irq.sv
// module: phy event interrupt control/status behind the mii management serial port
//
// Summary of operation
// R1: eight event flags sit in bits 0 to 7 and each goes to 1 when its phy event happens.
// R2: a read of the interrupt register returns the flags and then clears all eight.
// R3: bits 8 to 15 are writable enables, bit n+8 letting flag n raise the phy interrupt.
// R4: flag 7 is set on a jabber condition from the 10 Mb transmitter, enable bit 15.
// R5: flag 6 is set on a receive error, enable bit 14.
// R6: flag 5 is set when a new page arrives during auto-negotiation, enable bit 13.
// R7: flag 4 is set on a parallel detection fault, enable bit 12.
// R8: flag 3 is set when a link pulse burst with acknowledge arrives, enable bit 11.
// R9: flag 2 is set when link status goes from good to failed, enable bit 10.
// R10: flag 1 is set when the partner signals a remote fault, enable bit 9.
// R11: flag 0 is set when auto-negotiation completes successfully, enable bit 8.
// R12: the interrupt register is read at management address 0x11 over the serial port.
// R13: after reset all enables and flags read zero.
// R14: a read-only diagnostic register at address 0x12 reports the last negotiation, zero at reset.
// R15: the phy interrupt is high while any flag and its enable are both 1.
module pei_phy_event_irq
  import pei_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire pei_events_t event_pulse,
  input wire logic link_ok,
  input wire logic [15:0] autoneg_result,
  output logic phy_irq
);
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
  logic mdio_s1_r, mdio_s2_r;
  logic mdc_rise;

  // the first stages feed only the second stages
  always_ff @(posedge clock) begin
    if (rst) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_s3_r <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end else begin
      mdc_s1_r <= mdc;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      mdio_s1_r <= mdio_i;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  // mdc is slow next to the 10 MHz clock, so an edge detect is enough
  assign mdc_rise = mdc_s2_r & ~mdc_s3_r;

  // ***************************************************
  // register storage
  // ***************************************************
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] enables_r;
  logic [15:0] diag_r;
  logic link_ok_d_r;
  logic rd_clr_r;
  logic wr_en_r;
  logic [15:0] wr_data_r;
  pei_events_t ev;

  function automatic logic [15:0] read_word(input logic [4:0] addr, input logic [7:0] en,
                                            input logic [7:0] fl, input logic [15:0] dg);
    if (addr == PEI_ADDR_IRQ_CTRL_STATUS) begin
      read_word = {en, fl};
    end else if (addr == PEI_ADDR_AUTONEG_DIAG) begin
      read_word = dg;
    end else begin
      read_word = 16'h0000;
    end
  endfunction

  function automatic logic addr_hit(input logic [4:0] addr);
    addr_hit = (addr == PEI_ADDR_IRQ_CTRL_STATUS) || (addr == PEI_ADDR_AUTONEG_DIAG);
  endfunction

  // ***************************************************
  // management frame engine
  // ***************************************************
  pei_state_t state_r;
  logic [5:0] pre_cnt_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_r;
  logic [1:0] op_r;
  logic [4:0] phyad_r;
  logic [4:0] regad_r;
  logic [15:0] rd_sh_r;
  logic sel_r;
  logic bit_in;
  logic read_sel;
  logic write_sel;

  assign bit_in = mdio_s2_r;
  assign read_sel = sel_r && (op_r == PEI_OP_READ);
  assign write_sel = sel_r && (op_r == PEI_OP_WRITE);

  // a frame needs a full preamble; suppressed preambles are not accepted
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= PEI_ST_IDLE;
      pre_cnt_r <= PEI_PRE_ZERO;
      bit_cnt_r <= PEI_CNT_ZERO;
      shift_r <= 16'h0000;
      op_r <= 2'h0;
      phyad_r <= 5'h00;
      regad_r <= 5'h00;
      sel_r <= 1'b0;
    end else begin
      if (mdc_rise) begin
        shift_r <= {shift_r[14:0], bit_in};
        bit_cnt_r <= bit_cnt_r + PEI_CNT_ONE;
        case (state_r)
          PEI_ST_IDLE: begin
            if (bit_in) begin
              if (pre_cnt_r != PEI_PREAMBLE_LEN) begin
                pre_cnt_r <= pre_cnt_r + PEI_PRE_ONE;
              end
            end else begin
              pre_cnt_r <= PEI_PRE_ZERO;
              if (pre_cnt_r == PEI_PREAMBLE_LEN) begin
                state_r <= PEI_ST_START;
              end
            end
          end
          PEI_ST_START: begin
            bit_cnt_r <= PEI_CNT_ZERO;
            state_r <= bit_in ? PEI_ST_OP : PEI_ST_IDLE;
          end
          PEI_ST_OP: begin
            if (bit_cnt_r == PEI_CNT_OP_LAST) begin
              op_r <= {shift_r[0], bit_in};
              bit_cnt_r <= PEI_CNT_ZERO;
              if ({shift_r[0], bit_in} == PEI_OP_READ || {shift_r[0], bit_in} == PEI_OP_WRITE) begin
                state_r <= PEI_ST_PHYAD;
              end else begin
                state_r <= PEI_ST_IDLE;
              end
            end
          end
          PEI_ST_PHYAD: begin
            if (bit_cnt_r == PEI_CNT_ADDR_LAST) begin
              phyad_r <= {shift_r[3:0], bit_in};
              bit_cnt_r <= PEI_CNT_ZERO;
              state_r <= PEI_ST_REGAD;
            end
          end
          PEI_ST_REGAD: begin
            if (bit_cnt_r == PEI_CNT_ADDR_LAST) begin
              regad_r <= {shift_r[3:0], bit_in};
              sel_r <= (phyad_r == PHY_ADDR) && addr_hit({shift_r[3:0], bit_in}); // R12
              bit_cnt_r <= PEI_CNT_ZERO;
              state_r <= PEI_ST_TA;
            end
          end
          PEI_ST_TA: begin
            if (bit_cnt_r != PEI_CNT_ZERO) begin
              bit_cnt_r <= PEI_CNT_ZERO;
              state_r <= PEI_ST_DATA;
            end
          end
          PEI_ST_DATA: begin
            if (bit_cnt_r == PEI_CNT_DATA_LAST) begin
              pre_cnt_r <= PEI_PRE_ZERO;
              state_r <= PEI_ST_IDLE;
            end
          end
          default: begin
            state_r <= PEI_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ***************************************************
  // read data driver
  // ***************************************************
  // the pin turns around only for a selected read, so a stray frame never fights the master
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_sh_r <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        PEI_ST_TA: begin
          if (read_sel) begin
            if (bit_cnt_r == PEI_CNT_ZERO) begin
              // turnaround zero, and the word is frozen here so the clear is safe
              mdio_oe <= 1'b1; // R12
              mdio_o <= 1'b0;
              rd_sh_r <= read_word(regad_r, enables_r, flags_r, diag_r); // R12 R14
            end else begin
              mdio_o <= rd_sh_r[15];
              rd_sh_r <= {rd_sh_r[14:0], 1'b0};
            end
          end
        end
        PEI_ST_DATA: begin
          if (bit_cnt_r == PEI_CNT_DATA_LAST) begin
            mdio_oe <= 1'b0;
            mdio_o <= 1'b0;
          end else if (read_sel) begin
            mdio_o <= rd_sh_r[15];
            rd_sh_r <= {rd_sh_r[14:0], 1'b0};
          end
        end
        default: begin
          mdio_oe <= 1'b0;
          mdio_o <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************************
  // register access strobes
  // ***************************************************
  // one-clock strobes; flags and enables act on them a clock later
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_clr_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      rd_clr_r <= 1'b0;
      wr_en_r <= 1'b0;
      if (mdc_rise && read_sel && state_r == PEI_ST_TA && bit_cnt_r == PEI_CNT_ZERO) begin
        rd_clr_r <= (regad_r == PEI_ADDR_IRQ_CTRL_STATUS); // R2
      end
      if (mdc_rise && write_sel && state_r == PEI_ST_DATA && bit_cnt_r == PEI_CNT_DATA_LAST) begin
        wr_en_r <= (regad_r == PEI_ADDR_IRQ_CTRL_STATUS); // R3
        wr_data_r <= {shift_r[14:0], bit_in};
      end
    end
  end

  // ***************************************************
  // event flags
  // ***************************************************
  always_comb begin
    ev = event_pulse;
    // only the good-to-failed edge counts, recovery is silent
    ev.link_drop = link_ok_d_r & ~link_ok; // R9
  end

  always_comb begin
    flags_nxt = flags_r;
    if (rd_clr_r) begin
      flags_nxt = PEI_FLAGS_RESET; // R2
    end
    // an event landing on the clearing read survives into the next read
    flags_nxt = flags_nxt | ev; // R1 R4 R5 R6 R7 R8 R10 R11
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= PEI_FLAGS_RESET; // R13
      link_ok_d_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      link_ok_d_r <= link_ok;
    end
  end

  // ***************************************************
  // enables and diagnostic
  // ***************************************************
  // writes to the low byte are ignored, flags only clear by reading
  always_ff @(posedge clock) begin
    if (rst) begin
      enables_r <= PEI_ENABLES_RESET; // R13
    end else if (wr_en_r) begin
      enables_r <= wr_data_r[PEI_EN_MSB:PEI_EN_LSB]; // R3
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      diag_r <= PEI_AUTONEG_DIAG_RESET; // R14
    end else begin
      diag_r <= autoneg_result;
    end
  end

  // ***************************************************
  // interrupt line
  // ***************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      phy_irq <= 1'b0;
    end else begin
      phy_irq <= |(flags_r & enables_r); // R15 R3
    end
  end

endmodule

// ===== dv/pei_irq_asserts.sv
// checker: port-level properties of the phy event interrupt block
module pei_irq_asserts
  import pei_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire pei_events_t event_pulse,
  input wire logic link_ok,
  input wire logic phy_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************************
  // assertions
  // ***************************************************
  wire any_ev = |event_pulse;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_rst_irq_low: assert property (disable iff (1'b0) rst |=> !phy_irq)
    else $error("irq high after reset");
  a_rst_oe_low: assert property (disable iff (1'b0) rst |=> !mdio_oe)
    else $error("mdio driven after reset");
  a_ta_drive_zero: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround bit not zero");
  a_oe_min_len: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
    else $error("read drive too short");
  a_oe_bounded: assert property ($rose(mdio_oe) |-> ##[8:1000] !mdio_oe)
    else $error("read drive never released");
  a_oe_after_rise: assert property ($rose(mdio_oe) |-> $past(mdc, 3) || $past(mdc, 4))
    else $error("drive not tied to clock rise");
  // irq may only rise from an event, a link drop or the end of a write
  // a write shows on irq five samples after the first high sample of its last mdc rise
  a_irq_rise_cause: assert property ($rose(phy_irq) |-> $past(any_ev, 2) ||
    ($past(link_ok, 3) && !$past(link_ok, 2)) || ($past(mdc, 5) && !$past(mdc, 6)))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(phy_irq) |-> $past(mdio_oe) ||
    $past(mdio_oe, 2) || ($past(mdc, 5) && !$past(mdc, 6)))
    else $error("irq fell without read or write");
  c_irq_rise: cover property ($rose(phy_irq));
  c_irq_fall: cover property ($fell(phy_irq));
  c_read: cover property ($rose(mdio_oe));
endmodule

bind pei_phy_event_irq pei_irq_asserts pei_irq_asserts_inst (.clock, .rst, .mdc, .mdio_o,
  .mdio_oe, .event_pulse, .link_ok, .phy_irq);

// ===== dv/pei_mgmt_model.sv
// partner model: management master driving mdc and its share of mdio
module pei_mgmt_model (
  input wire logic clock,
  input wire logic mdio,
  output logic mdc,
  output logic m_o,
  output logic m_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mdc = 1'b0;
    m_o = 1'b0;
    m_oe = 1'b0;
  end
  // five clocks per half period leaves margin over the input synchronisers
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [63:0] v;
    v = {32'hffff_ffff, 2'h1, op, 5'h00, ra, 2'h2, wd};
    rd = 16'hffff;
    for (int i = 0; i < 64; i++) begin
      @(negedge clock);
      mdc = 1'b0;
      m_oe = !(op == 2'h2 && i >= 46);
      m_o = v[63 - i];
      repeat (5) @(negedge clock);
      if (i >= 48) rd[63 - i] = mdio;
      mdc = 1'b1;
      repeat (4) @(negedge clock);
    end
    @(negedge clock);
    mdc = 1'b0;
    m_oe = 1'b0;
  endtask
endmodule

// ===== dv/tb_top.sv
// testbench: exercises the phy event interrupt block through its management port
module tb_top
  import pei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic link_ok = 1'b1;
  logic [15:0] autoneg_result = 16'h0000;
  pei_events_t event_pulse = '0;
  logic mdc, m_o, m_oe, mdio_o, mdio_oe, phy_irq;
  logic [15:0] rd;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  // released line floats high through the pull-up
  wire mdio = mdio_oe ? mdio_o : (m_oe ? m_o : 1'b1);
  pei_phy_event_irq pei_phy_event_irq_inst (.clock, .rst, .mdc, .mdio_i(mdio), .mdio_o,
    .mdio_oe, .event_pulse, .link_ok, .autoneg_result, .phy_irq);
  pei_mgmt_model pei_mgmt_model_inst (.clock, .mdio, .mdc, .m_o, .m_oe);
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      close_out;
    end
  end
  // ***************************************************
  // helpers
  // ***************************************************
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [4:0] ra);
    pei_mgmt_model_inst.xfer(2'h2, ra, 16'h0000, rd);
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    pei_mgmt_model_inst.xfer(2'h1, ra, wd, d);
    repeat (4) @(negedge clock);
  endtask
  // flag 2 comes from a falling link status, not from its pulse input
  task automatic pulse(input int n);
    @(negedge clock);
    if (n == 2) link_ok = 1'b0;
    else event_pulse = pei_events_t'(8'(1 << n));
    @(negedge clock);
    link_ok = 1'b1;
    event_pulse = '0;
    repeat (2) @(negedge clock);
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    rd_reg(PEI_ADDR_IRQ_CTRL_STATUS);
    chk_word(rd, PEI_IRQ_CTRL_STATUS_RESET);
    rd_reg(PEI_ADDR_AUTONEG_DIAG);
    chk_word(rd, PEI_AUTONEG_DIAG_RESET);
    autoneg_result = 16'h5a3c;
    wr_reg(PEI_ADDR_AUTONEG_DIAG, 16'h0f0f);
    rd_reg(PEI_ADDR_AUTONEG_DIAG);
    chk_word(rd, 16'h5a3c);
    rd_reg(5'h05);
    chk_word(rd, 16'hffff);
    $display("test reset done");
  endtask
  task automatic t_flags;
    for (int n = 0; n < 8; n++) begin
      pulse(n);
      chk_bit(phy_irq, 1'b0);
      rd_reg(PEI_ADDR_IRQ_CTRL_STATUS);
      chk_word(rd, 16'(1 << n));
      rd_reg(PEI_ADDR_IRQ_CTRL_STATUS);
      chk_word(rd, 16'h0000);
    end
    $display("test flags done");
  endtask
  task automatic t_irq;
    wr_reg(PEI_ADDR_IRQ_CTRL_STATUS, 16'hffff);
    rd_reg(PEI_ADDR_IRQ_CTRL_STATUS);
    chk_word(rd, 16'hff00);
    chk_bit(phy_irq, 1'b0);
    pulse(6);
    chk_bit(phy_irq, 1'b1);
    wr_reg(PEI_ADDR_IRQ_CTRL_STATUS, 16'hbf00);
    chk_bit(phy_irq, 1'b0);
    wr_reg(PEI_ADDR_IRQ_CTRL_STATUS, 16'hff00);
    chk_bit(phy_irq, 1'b1);
    rd_reg(PEI_ADDR_IRQ_CTRL_STATUS);
    chk_word(rd, 16'hff40);
    chk_bit(phy_irq, 1'b0);
    $display("test irq done");
  endtask
  task automatic t_rereset;
    pulse(0);
    chk_bit(phy_irq, 1'b1);
    rst = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    chk_bit(phy_irq, 1'b0);
    rd_reg(PEI_ADDR_IRQ_CTRL_STATUS);
    chk_word(rd, 16'h0000);
    $display("test rereset done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    t_reset;
    t_flags;
    t_irq;
    t_rereset;
    close_out;
  end
endmodule
